// [dv/lw_dma_host.sv]
`timescale 1ns/1ps
// dma word source standing in for the host controller
module lw_dma_host (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// control from the bench
	input  wire logic        go,
	input  wire logic [8:0]  n_words,
	input  wire logic [8:0]  crc_at,
	input  wire logic [31:0] base,
	// stream towards the device
	input  wire logic        dma_ready,
	output logic             dma_valid,
	output logic [31:0]      dma_data,
	output logic             dma_crc_err
);
	logic [8:0] cnt_ff;
	logic       run_ff;

	////////////////////////////////////////////////////////////////////////
	// an offer holds until the edge that takes it; after odd words the
	// source stalls a cycle so the sink sees both gaps and back-to-back words
	// idle data lines show the inverse of the last word, never a stale copy
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_ff      <= 9'h000;
			run_ff      <= 1'b0;
			dma_valid   <= 1'b0;
			dma_data    <= 32'h00000000;
			dma_crc_err <= 1'b0;
		end else if (go) begin
			cnt_ff      <= 9'h000;
			run_ff      <= 1'b1;
			dma_valid   <= 1'b1;
			dma_data    <= base;
			dma_crc_err <= (crc_at == 9'h000);
		end else if (run_ff && dma_valid && dma_ready) begin
			cnt_ff <= cnt_ff + 9'h001;
			if (dma_crc_err || (cnt_ff + 9'h001 == n_words) || cnt_ff[0]) begin
				dma_valid   <= 1'b0;
				dma_crc_err <= 1'b0;
				dma_data    <= ~dma_data;
				run_ff      <= !(dma_crc_err || (cnt_ff + 9'h001 == n_words));
			end else begin
				dma_data    <= base + 32'(cnt_ff) + 32'h00000001;
				dma_crc_err <= (cnt_ff + 9'h001 == crc_at);
			end
		end else if (run_ff && !dma_valid) begin
			dma_valid   <= 1'b1;
			dma_data    <= base + 32'(cnt_ff);
			dma_crc_err <= (cnt_ff == crc_at);
		end
	end
endmodule

// [dv/lw_log_write_tb.sv]
`timescale 1ns/1ps
module lw_log_write_tb;
	import lw_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, go;
	logic [11:0] paddr;
	logic [31:0] pwdata, base, rd;
	logic [8:0]  n_words, crc_at;
	logic        err;
	wire  [31:0] prdata, dma_data;
	wire         pready, pslverr, dma_valid, dma_crc_err, dma_ready, irq;
	int          n_mismatch, check_count;
	// abort cases: opcode, log, count, first sector
	logic [7:0]  ab_op[8]  = '{8'h12, 8'h3f, 8'h57, 8'h3f, 8'h3f, 8'h57, 8'h3f, 8'h3f};
	logic [7:0]  ab_lg[8]  = '{8'h01, 8'h02, 8'h00, 8'h03, 8'h01, 8'h01, 8'h01, 8'h01};
	logic [15:0] ab_cn[8]  = '{16'h1, 16'h1, 16'h1, 16'h1, 16'h0, 16'h101, 16'h1, 16'h2};
	logic [15:0] ab_st[8]  = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h100, 16'h1};

	lw_log_write i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dma_valid(dma_valid), .dma_data(dma_data), .dma_crc_err(dma_crc_err), .dma_ready(dma_ready), .irq(irq));
	lw_dma_host i_host (.clk(pclk), .rstn(presetn), .go(go), .n_words(n_words), .crc_at(crc_at), .base(base),
		.dma_ready(dma_ready), .dma_valid(dma_valid), .dma_data(dma_data), .dma_crc_err(dma_crc_err));

	always #20 pclk = ~pclk;

	////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		if (n_mismatch == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// one apb transfer; the request stands until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			n_mismatch++;
			$display("unexpected at %0t: bus never answered", $time);
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, $sformatf("read %h", a));
	endtask

	// irq is looked at once the edge's updates have landed
	task automatic irq_chk(input logic exp);
		@(negedge pclk);
		chk({31'h0, irq}, {31'h0, exp}, "irq level");
	endtask

	task automatic cmd(input logic [7:0] op, input logic [7:0] lg, input logic [15:0] cn, input logic [15:0] st);
		apb(1'b1, OFS_SECT_CNT, {16'h0, cn});
		apb(1'b1, OFS_LOG_ADDR, {24'h0, lg});
		apb(1'b1, OFS_START, {16'h0, st});
		apb(1'b1, OFS_CMD, {24'h0, op});
	endtask

	task automatic pio_words(input int s);
		for (int k = 0; k < 128; k++)
			apb(1'b1, OFS_DATA, 32'hc0de0000 + 32'(s * 128 + k));
	endtask

	task automatic peek(input logic [9:0] idx, input logic [31:0] exp);
		apb(1'b1, OFS_RD_PTR, {22'h0, idx});
		rchk(OFS_RD_DATA, exp);
	endtask

	task automatic dma_run(input logic [8:0] c, input logic [31:0] b);
		int n;
		@(posedge pclk);
		go      <= 1'b1;
		n_words <= 9'h080;
		crc_at  <= c;
		base    <= b;
		@(posedge pclk);
		go <= 1'b0;
		n = 0;
		do begin
			apb(1'b0, OFS_STATUS, 32'h0);
			n++;
		end while (rd[STS_BSY] === 1'b1 && n < 400);
		if (rd[STS_BSY] !== 1'b0) begin
			n_mismatch++;
			$display("unexpected at %0t: dma transfer hung", $time);
			complete_run();
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		{pclk, presetn, psel, penable, pwrite, go, paddr, pwdata} = '0;
		{n_words, base, crc_at, n_mismatch, check_count} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rchk(OFS_STATUS, 32'h50);
		rchk(OFS_ERROR, 32'h0);
		apb(1'b0, 12'h100, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped flag");
		// slot 1 enabled size 2, slot 2 read-only, slot 3 disabled
		apb(1'b1, OFS_DIR0 + 12'h004, 32'h00020002);
		apb(1'b1, OFS_DIR0 + 12'h008, 32'h00030002);
		apb(1'b1, OFS_DIR0 + 12'h00c, 32'h00000001);
		rchk(OFS_DIR0 + 12'h004, 32'h00020002);
		chk({31'h0, err}, 32'h0, "mapped flag");
		apb(1'b1, OFS_IRQ_EN, 32'h3);
		cmd(OP_LOG_PIO, 8'h01, 16'h2, 16'h0);
		rchk(OFS_STATUS, 32'h58);
		pio_words(0);
		rchk(OFS_IRQ_STS, 32'h1);
		irq_chk(1'b1);
		rchk(OFS_STATUS, 32'h58);
		apb(1'b1, OFS_IRQ_CLR, 32'h1);
		irq_chk(1'b0);
		// taskfile and opcode writes during the data phase must not land
		apb(1'b1, OFS_SECT_CNT, 32'h5);
		apb(1'b1, OFS_CMD, 32'h57);
		rchk(OFS_SECT_CNT, 32'h2);
		rchk(OFS_CMD, 32'h3f);
		rchk(OFS_STATUS, 32'h58);
		pio_words(1);
		rchk(OFS_IRQ_STS, 32'h3);
		rchk(OFS_STATUS, 32'h50);
		apb(1'b1, OFS_IRQ_CLR, 32'h7);
		// dma into the second sector of the log
		cmd(OP_LOG_DMA, 8'h01, 16'h1, 16'h1);
		rchk(OFS_STATUS, 32'hd0);
		dma_run(9'h1ff, 32'h7a000000);
		chk(rd, 32'h50, "dma end status");
		rchk(OFS_IRQ_STS, 32'h2);
		rchk(OFS_ERROR, 32'h0);
		apb(1'b1, OFS_IRQ_CLR, 32'h7);
		// third word carries a crc fault
		cmd(OP_LOG_DMA, 8'h01, 16'h1, 16'h0);
		dma_run(9'h002, 32'h3b000000);
		chk(rd, 32'h51, "crc status");
		rchk(OFS_ERROR, 32'h80);
		rchk(OFS_IRQ_STS, 32'h4);
		apb(1'b1, OFS_IRQ_CLR, 32'h7);
		// every abort leaves the store untouched, data writes are dropped
		for (int i = 0; i < 8; i++) begin
			cmd(ab_op[i], ab_lg[i], ab_cn[i], ab_st[i]);
			rchk(OFS_ERROR, 32'h04);
			rchk(OFS_STATUS, 32'h51);
			apb(1'b1, OFS_DATA, 32'hdead0000);
		end
		rchk(OFS_IRQ_STS, 32'h4);
		rchk(OFS_START, 32'h1);
		rchk(OFS_LOG_ADDR, 32'h1);
		irq_chk(1'b0);
		apb(1'b1, OFS_IRQ_EN, 32'h7);
		irq_chk(1'b1);
		apb(1'b1, OFS_IRQ_CLR, 32'h4);
		irq_chk(1'b0);
		peek(10'd256, 32'h3b000000);
		peek(10'd257, 32'h3b000001);
		peek(10'd258, 32'hc0de0002);
		peek(10'd383, 32'hc0de007f);
		peek(10'd389, 32'h7a000005);
		peek(10'd511, 32'h7a00007f);
		complete_run();
	end
endmodule

// [rtl/lw_log_store.sv]
`timescale 1ns/1ps
module lw_log_store
	import lw_pkg::*;
(
	// clock
	input  wire logic              clk,
	// write port
	input  wire logic              we,
	input  wire logic [MEM_AW-1:0] waddr,
	input  wire logic [31:0]       wdata,
	// read port
	input  wire logic [MEM_AW-1:0] raddr,
	output logic      [31:0]       rdata
);

	////////////////////////////////////////////////////////////////////////
	// log sector storage; no reset, contents are undefined until written
	logic [31:0] mem_ff [MEM_DEPTH];

	// write port
	always_ff @(posedge clk) begin
		if (we) begin
			mem_ff[waddr] <= wdata;
		end
	end

	// read port is asynchronous so the bus slave can latch it in setup
	assign rdata = mem_ff[raddr];

endmodule

// [rtl/lw_log_write.sv]
// How it works
// R1 - opcode 3fh starts the pio log write
// R2 - opcode 57h is the dma form, same checks
// R3 - accept count sectors of 512 bytes each
// R4 - pio: interrupt after every drq block
// R5 - host gives 16-bit sector count, two bytes
// R6 - abort when count exceeds directory log size
// R7 - data stored from the first requested sector
// R8 - log address byte; read-only log aborts
// R9 - host gives 16-bit start sector, two bytes
// R10 - abort on unsupported log or bad values
// R11 - error bits limited; crc only for dma
// R12 - completion clears busy, fault, corrected bits
// R13 - feature and cylinder high fields are ignored
// R14 - abort sets abort and error, writes nothing
`timescale 1ns/1ps
module lw_log_write
	import lw_pkg::*;
(
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// dma data stream
	input  wire logic        dma_valid,
	input  wire logic [31:0] dma_data,
	input  wire logic        dma_crc_err,
	output logic             dma_ready,
	// interrupt
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////
	// state
	lw_state_t           state_ff, nxt_state;
	logic [15:0]         cnt_ff, nxt_cnt;
	logic [7:0]          lsa_ff, nxt_lsa;
	logic [15:0]         start_ff, nxt_start;
	logic [7:0]          cmd_ff, nxt_cmd;
	logic [7:0]          err_ff, nxt_err;
	logic                dma_mode_ff, nxt_dma_mode;
	logic [SLOT_W-1:0]   slot_ff, nxt_slot;
	logic [15:0]         sect_ff, nxt_sect;
	logic [15:0]         left_ff, nxt_left;
	logic [WORD_W-1:0]   word_ff, nxt_word;
	logic [IRQ_W-1:0]    ists_ff, nxt_ists;
	logic [IRQ_W-1:0]    ien_ff, nxt_ien;
	logic [MEM_AW-1:0]   rptr_ff, nxt_rptr;
	logic [31:0]         prdata_ff, nxt_prdata;
	logic [DIR_W-1:0]    dir_ff [LOG_SLOTS];
	logic [DIR_W-1:0]    nxt_dir [LOG_SLOTS];

	// bus decode and datapath
	logic                apb_wr;
	logic                addr_hit;
	logic                cmd_wr;
	logic                pio_acc;
	logic                dma_acc;
	logic                crc_bad;
	logic                mem_we;
	logic                sect_end;
	logic                last_sect;
	logic [31:0]         mem_wdata;
	logic [31:0]         mem_rdata;
	logic [MEM_AW-1:0]   mem_waddr;
	logic [7:0]          status_flags;
	logic [31:0]         rd_mux;

	// command checks
	logic [SLOT_W-1:0]   sel_slot;
	logic [15:0]         dir_size;
	logic [15:0]         cap;
	logic [16:0]         last_end;
	logic                op_ok;
	logic                log_ro;
	logic                log_off;
	logic                over_dir;
	logic                vals_bad;
	logic                cmd_ok;
	logic [IRQ_W-1:0]    ev;

	////////////////////////////////////////////////////////////////////////
	// apb decode; the slave never waits
	assign pready   = 1'b1;
	assign apb_wr   = psel & penable & pwrite;
	assign addr_hit = (paddr[1:0] == 2'b00) && (paddr <= OFS_DIR0 + 12'h00c);
	assign pslverr  = psel & penable & ~addr_hit;
	assign prdata   = prdata_ff;
	assign cmd_wr   = apb_wr && (paddr == OFS_CMD);

	// status: ready and seek complete stand, fault/corrected/index stay low
	always_comb begin
		status_flags          = 8'h00;
		status_flags[STS_BSY] = (state_ff == LW_XFER) & dma_mode_ff; // R12
		status_flags[STS_RDY] = 1'b1; // R12
		status_flags[STS_DSC] = 1'b1; // R12
		status_flags[STS_DRQ] = (state_ff == LW_XFER) & ~dma_mode_ff;
		status_flags[STS_ERR] = |err_ff; // R12
	end

	// read mux, latched in the setup phase so prdata comes from a flop
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			OFS_SECT_CNT: rd_mux = {16'h0000, cnt_ff};
			OFS_LOG_ADDR: rd_mux = {24'h000000, lsa_ff};
			OFS_START:    rd_mux = {16'h0000, start_ff};
			OFS_CMD:      rd_mux = {24'h000000, cmd_ff};
			OFS_ERROR:    rd_mux = {24'h000000, err_ff};
			OFS_STATUS:   rd_mux = {24'h000000, status_flags};
			OFS_IRQ_STS:  rd_mux = {29'h00000000, ists_ff};
			OFS_IRQ_EN:   rd_mux = {29'h00000000, ien_ff};
			OFS_RD_PTR:   rd_mux = {22'h000000, rptr_ff};
			OFS_RD_DATA:  rd_mux = mem_rdata;
			default: begin
				if (addr_hit && paddr >= OFS_DIR0) begin
					rd_mux = {14'h0000, dir_ff[paddr[3:2]]};
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// log directory slots; slot 0 holds the directory itself
	for (genvar g = 0; g < LOG_SLOTS; g++) begin : g_dir
		always_comb begin
			nxt_dir[g] = dir_ff[g];
			if (apb_wr && paddr == OFS_DIR0 + 12'(4 * g)) begin
				nxt_dir[g] = pwdata[DIR_W-1:0];
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				dir_ff[g] <= DIR_RESET;
			end else begin
				dir_ff[g] <= nxt_dir[g];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// command validation, evaluated on the cycle the opcode is written
	assign sel_slot = lsa_ff[SLOT_W-1:0]; // R8
	assign dir_size = dir_ff[sel_slot][15:0];
	assign cap      = (dir_size < LOG_CAP) ? dir_size : LOG_CAP;
	assign last_end = {1'b0, start_ff} + {1'b0, cnt_ff}; // R9
	assign op_ok    = (pwdata[7:0] == OP_LOG_PIO) || (pwdata[7:0] == OP_LOG_DMA); // R1 R2
	assign log_ro   = (sel_slot == 2'd0) || dir_ff[sel_slot][DIR_RO_BIT]; // R8
	// the whole address byte must name a slot; upper codes are unsupported
	assign log_off  = (lsa_ff >= 8'(LOG_SLOTS)) || ~dir_ff[sel_slot][DIR_FEAT_BIT]; // R10
	assign over_dir = cnt_ff > dir_size; // R6
	assign vals_bad = (cnt_ff == 16'h0000) || (last_end > {1'b0, cap}); // R10
	assign cmd_ok   = op_ok & ~log_ro & ~log_off & ~over_dir & ~vals_bad;

	////////////////////////////////////////////////////////////////////////
	// data path; a crc-flagged dma word is dropped and ends the command
	assign dma_ready = (state_ff == LW_XFER) & dma_mode_ff; // R2
	assign dma_acc   = dma_valid & dma_ready;
	assign crc_bad   = dma_acc & dma_crc_err; // R11
	assign pio_acc   = apb_wr && (paddr == OFS_DATA) && (state_ff == LW_XFER) && !dma_mode_ff;
	assign mem_we    = (pio_acc | dma_acc) & ~crc_bad; // R3
	assign mem_wdata = dma_mode_ff ? dma_data : pwdata;
	assign mem_waddr = {slot_ff, sect_ff[SECT_W-1:0], word_ff}; // R7
	assign sect_end  = mem_we && (word_ff == WORD_LAST); // R3
	assign last_sect = sect_end && (left_ff == 16'h0001);

	lw_log_store u_store (
		.clk   (pclk),
		.we    (mem_we),
		.waddr (mem_waddr),
		.wdata (mem_wdata),
		.raddr (rptr_ff),
		.rdata (mem_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// next-state logic for the command engine and its registers
	always_comb begin
		nxt_state    = state_ff;
		nxt_cnt      = cnt_ff;
		nxt_lsa      = lsa_ff;
		nxt_start    = start_ff;
		nxt_cmd      = cmd_ff;
		nxt_err      = err_ff;
		nxt_dma_mode = dma_mode_ff;
		nxt_slot     = slot_ff;
		nxt_sect     = sect_ff;
		nxt_left     = left_ff;
		nxt_word     = word_ff;
		nxt_ien      = ien_ff;
		nxt_rptr     = rptr_ff;
		nxt_prdata   = prdata_ff;
		ev           = '0;
		if (psel && !penable && !pwrite) begin
			nxt_prdata = rd_mux;
		end
		if (apb_wr && paddr == OFS_IRQ_EN) begin
			nxt_ien = pwdata[IRQ_W-1:0];
		end
		if (apb_wr && paddr == OFS_RD_PTR) begin
			nxt_rptr = pwdata[MEM_AW-1:0];
		end
		case (state_ff)
			LW_IDLE: begin
				// taskfile loads; feature and cylinder high have no home here
				if (apb_wr && paddr == OFS_SECT_CNT) begin
					nxt_cnt = pwdata[15:0]; // R5 R13
				end
				if (apb_wr && paddr == OFS_LOG_ADDR) begin
					nxt_lsa = pwdata[7:0]; // R8
				end
				if (apb_wr && paddr == OFS_START) begin
					nxt_start = pwdata[15:0]; // R9
				end
				if (cmd_wr) begin
					nxt_cmd      = pwdata[7:0];
					nxt_err      = ERR_RESET;
					nxt_dma_mode = (pwdata[7:0] == OP_LOG_DMA); // R2
					if (cmd_ok) begin
						nxt_state = LW_XFER; // R1 R2
						nxt_slot  = sel_slot;
						nxt_sect  = start_ff; // R7
						nxt_left  = cnt_ff; // R3
						nxt_word  = '0;
					end else begin
						nxt_err[ERR_ABT] = 1'b1; // R14
						ev[IRQ_FAIL]     = 1'b1;
					end
				end
			end
			LW_XFER: begin
				// a command written mid-transfer is ignored
				if (crc_bad) begin
					nxt_err[ERR_CRC] = 1'b1; // R11
					nxt_state        = LW_IDLE;
					ev[IRQ_FAIL]     = 1'b1;
				end else if (mem_we) begin
					nxt_word = word_ff + 7'h01;
					if (sect_end) begin
						nxt_sect        = sect_ff + 16'h0001;
						nxt_left        = left_ff - 16'h0001;
						ev[IRQ_BLOCK]   = ~dma_mode_ff; // R4
					end
					if (last_sect) begin
						nxt_state    = LW_IDLE; // R12
						ev[IRQ_DONE] = 1'b1;
					end
				end
			end
			default: begin
				nxt_state = LW_IDLE;
			end
		endcase
		// sticky events: a set in the same cycle as its clear wins
		nxt_ists = ists_ff;
		if (apb_wr && paddr == OFS_IRQ_CLR) begin
			nxt_ists = ists_ff & ~pwdata[IRQ_W-1:0];
		end
		nxt_ists = nxt_ists | ev;
	end

	// registers of the command engine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff    <= LW_IDLE;
			cnt_ff      <= 16'h0000;
			lsa_ff      <= 8'h00;
			start_ff    <= 16'h0000;
			cmd_ff      <= 8'h00;
			err_ff      <= ERR_RESET;
			dma_mode_ff <= 1'b0;
			slot_ff     <= '0;
			sect_ff     <= 16'h0000;
			left_ff     <= 16'h0000;
			word_ff     <= '0;
			ists_ff     <= '0;
			ien_ff      <= '0;
			rptr_ff     <= '0;
			prdata_ff   <= 32'h0000_0000;
		end else begin
			state_ff    <= nxt_state;
			cnt_ff      <= nxt_cnt;
			lsa_ff      <= nxt_lsa;
			start_ff    <= nxt_start;
			cmd_ff      <= nxt_cmd;
			err_ff      <= nxt_err;
			dma_mode_ff <= nxt_dma_mode;
			slot_ff     <= nxt_slot;
			sect_ff     <= nxt_sect;
			left_ff     <= nxt_left;
			word_ff     <= nxt_word;
			ists_ff     <= nxt_ists;
			ien_ff      <= nxt_ien;
			rptr_ff     <= nxt_rptr;
			prdata_ff   <= nxt_prdata;
		end
	end

	// level interrupt while any enabled event is pending
	assign irq = |(ists_ff & ien_ff);

	////////////////////////////////////////////////////////////////////////
	// checks; word total lets the completion be tied to the sector count
	logic [23:0] wr_total_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_total_ff <= 24'h000000;
		end else if (cmd_wr && state_ff == LW_IDLE) begin
			wr_total_ff <= 24'h000000;
		end else if (mem_we) begin
			wr_total_ff <= wr_total_ff + 24'h000001;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_idle_cmd;
		cmd_wr && state_ff == LW_IDLE;
	endsequence

	sequence s_pio_start;
		s_idle_cmd ##0 (cmd_ok && pwdata[7:0] == OP_LOG_PIO);
	endsequence

	sequence s_dma_start;
		s_idle_cmd ##0 (cmd_ok && pwdata[7:0] == OP_LOG_DMA);
	endsequence

	pio_cmd_start_a: assert property (s_pio_start |=> state_ff == LW_XFER && status_flags[STS_DRQ]) // R1
		else $error("pio log write did not enter data phase");
	dma_cmd_start_a: assert property (s_dma_start |=> dma_ready && status_flags[STS_BSY] ##0 !status_flags[STS_DRQ]) // R2
		else $error("dma log write did not open the stream");
	sector_total_a: assert property (last_sect |-> wr_total_ff + 24'h000001 == {1'b0, cnt_ff, 7'h00}) // R3
		else $error("completed transfer does not match sector count");
	pio_block_irq_a: assert property (sect_end && !dma_mode_ff |=> ists_ff[IRQ_BLOCK]) // R4
		else $error("pio block end raised no interrupt event");
	over_dir_abort_a: assert property (s_idle_cmd ##0 over_dir |=> state_ff == LW_IDLE && err_ff[ERR_ABT]) // R6
		else $error("count above directory size not aborted");
	first_sector_a: assert property (s_idle_cmd ##0 cmd_ok |=> sect_ff == $past(start_ff) && word_ff == '0) // R7
		else $error("transfer did not begin at the requested sector");
	ro_log_abort_a: assert property (s_idle_cmd ##0 log_ro |=> err_ff[ERR_ABT] ##0 status_flags[STS_ERR]) // R8
		else $error("read-only log write not aborted");
	bad_value_abort_a: assert property (s_idle_cmd ##0 (log_off || vals_bad) |=> !dma_ready && err_ff[ERR_ABT]) // R10
		else $error("unsupported log or bad values not aborted");
	pio_no_crc_a: assert property (err_ff[ERR_CRC] |-> dma_mode_ff && !err_ff[ERR_UNC] && !err_ff[ERR_IDN]) // R11
		else $error("crc flag reported outside the dma form");
	done_status_a: assert property (last_sect |=> status_flags[7:5] == 3'b010 && !status_flags[STS_COR]) // R12
		else $error("completion status bits wrong");
	abort_no_write_a: assert property (s_idle_cmd ##0 !cmd_ok |=> !mem_we [*2]) // R14
		else $error("aborted command wrote into the log");

endmodule

// [rtl/lw_pkg.sv]
package lw_pkg;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets on the apb bus
	localparam logic [11:0] OFS_SECT_CNT  = 12'h000;
	localparam logic [11:0] OFS_LOG_ADDR  = 12'h004;
	localparam logic [11:0] OFS_START     = 12'h008;
	localparam logic [11:0] OFS_CMD       = 12'h00c;
	localparam logic [11:0] OFS_ERROR     = 12'h010;
	localparam logic [11:0] OFS_STATUS    = 12'h014;
	localparam logic [11:0] OFS_DATA      = 12'h018;
	localparam logic [11:0] OFS_IRQ_STS   = 12'h01c;
	localparam logic [11:0] OFS_IRQ_CLR   = 12'h020;
	localparam logic [11:0] OFS_IRQ_EN    = 12'h024;
	localparam logic [11:0] OFS_RD_PTR    = 12'h028;
	localparam logic [11:0] OFS_RD_DATA   = 12'h02c;
	localparam logic [11:0] OFS_DIR0      = 12'h030;

	////////////////////////////////////////////////////////////////////////
	// command opcodes
	localparam logic [7:0]  OP_LOG_PIO    = 8'h3f;
	localparam logic [7:0]  OP_LOG_DMA    = 8'h57;

	////////////////////////////////////////////////////////////////////////
	// log store geometry: 512-byte sectors as 128 words of 32 bits
	localparam int unsigned WORD_W        = 7;
	localparam logic [6:0]  WORD_LAST     = 7'h7f;
	localparam int unsigned SLOT_W        = 2;
	localparam int unsigned LOG_SLOTS     = 4;
	localparam int unsigned SECT_W        = 1;
	localparam logic [15:0] LOG_CAP       = 16'h0002;
	localparam int unsigned MEM_AW        = SLOT_W + SECT_W + WORD_W;
	localparam int unsigned MEM_DEPTH     = 1 << MEM_AW;

	////////////////////////////////////////////////////////////////////////
	// error flag bit positions
	localparam int unsigned ERR_CRC       = 7;
	localparam int unsigned ERR_UNC       = 6;
	localparam int unsigned ERR_IDN       = 4;
	localparam int unsigned ERR_ABT       = 2;
	localparam logic [7:0]  ERR_RESET     = 8'h00;

	// status flag bit positions
	localparam int unsigned STS_BSY       = 7;
	localparam int unsigned STS_RDY       = 6;
	localparam int unsigned STS_DF        = 5;
	localparam int unsigned STS_DSC       = 4;
	localparam int unsigned STS_DRQ       = 3;
	localparam int unsigned STS_COR       = 2;
	localparam int unsigned STS_IDX       = 1;
	localparam int unsigned STS_ERR       = 0;

	////////////////////////////////////////////////////////////////////////
	// log directory slot layout
	localparam int unsigned DIR_W         = 18;
	localparam int unsigned DIR_RO_BIT    = 16;
	localparam int unsigned DIR_FEAT_BIT  = 17;
	localparam logic [17:0] DIR_RESET     = 18'h00000;

	// interrupt event bits
	localparam int unsigned IRQ_W         = 3;
	localparam int unsigned IRQ_BLOCK     = 0;
	localparam int unsigned IRQ_DONE      = 1;
	localparam int unsigned IRQ_FAIL      = 2;

	typedef enum logic [1:0] {
		LW_IDLE = 2'b01,
		LW_XFER = 2'b10
	} lw_state_t;

endpackage
